//--- pah_axis_device.sv
// Axis end of the positioning handshake: takes jobs from the controller,
// checks them, hands them to the motion core and acknowledges the outcome.
// Assumes the controller logic runs on core_clk, so link inputs need no synchroniser.
//
// Overview of operation
// - Job starts only on start request rising edge.
// - Mode bits select incremental, shortest, negative, positive.
// - At most one mode bit; none means absolute.
// - Inch bit makes linear targets inches.
// - Indexing bit reads target as unsigned index.
// - Real target: degrees rotary, mm/inch linear.
// - Feedrate in rpm for rotary axis or spindle.
// - Refused flag at start, traverse flag while moving.
// - Success raises reached flag with active high.
// - Active flag marks running job, feedback valid.
// - Failure raises error flag, active high, code.
// - Codes 30 moving, 50 jog/ref, 60 channel.
// - Codes 110 negative, 111 zero speed, 112 gear.
// - Codes 115 unreached, 120 not indexing, 121 index.
// - Codes 125 shortest, 126 negative, 127 positive impossible.
// - Codes 130-133 software and working-area limits.
// - Codes 100-109, 135-136 mirror kernel alarms.
// - Code 200 for serious system alarm.
// - Controller drops start only after an acknowledgement.
// - Start withdrawn clears acknowledgement and active flags.
// - Every further job needs a fresh edge.
// - Controller holds start high until acknowledged.
// - Dropping start never aborts; axial abort does.
//
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ns
module pah_axis_device (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  // Controller link
  pah_link_if.device                link,
  // Axis configuration
  input  wire logic                 axisIsRotary,
  input  wire logic                 axisIsSpindle,
  input  wire logic                 axisIsIndexing,
  input  wire logic [31:0]          indexCount,
  // Axis condition at start
  input  wire logic                 axisMovingAtHandover,
  input  wire logic                 axisJogOrRef,
  input  wire logic                 channelBlocksStart,
  input  wire logic                 gearStageValid,
  input  wire logic                 shortestPathOk,
  input  wire logic                 absNegOk,
  input  wire logic                 absPosOk,
  // Alarms and limits
  input  wire logic                 systemAlarm,
  input  wire logic                 kernelAlarmValid,
  input  wire logic [7:0]           kernelAlarmCode,
  input  wire logic                 swLimitPlus,
  input  wire logic                 swLimitMinus,
  input  wire logic                 workLimitPlus,
  input  wire logic                 workLimitMinus,
  // Motion core
  input  wire logic                 motionDone,
  input  wire logic                 motionNotReached,
  input  wire logic                 axialAbort,
  output logic                      motionStart,
  output logic                      motionStop,
  output pah_pkg::pah_move_t        motionMode,
  output pah_pkg::pah_unit_t        targetUnit,
  output logic                      feedRpm,
  output logic [31:0]               motionTarget,
  output logic [31:0]               motionFeed
);

  typedef struct packed {
    pah_pkg::pah_dev_state_t state;
    logic                    startPrev;
    logic                    activeFlag;
    logic                    reachedFlag;
    logic                    refusedFlag;
    logic                    travErrFlag;
    logic [7:0]              faultCode;
    logic                    motionStart;
    logic                    motionStop;
    pah_pkg::pah_move_t      motionMode;
    pah_pkg::pah_unit_t      targetUnit;
    logic                    feedRpm;
    logic [31:0]             motionTarget;
    logic [31:0]             motionFeed;
  } pah_dev_regs_t;

  pah_dev_regs_t r;
  pah_dev_regs_t next_r;

  logic       startEdge;
  logic [7:0] startFault;
  logic [7:0] runFault;
  logic       alarmEquiv;
  logic       feedNeg;
  logic       feedZero;
  logic       indexBad;

  always_comb begin
    next_r = r;
    next_r.motionStart = 1'b0;
    next_r.motionStop = 1'b0;
    next_r.startPrev = link.job_start_req;
    // Only a low-to-high step counts, a level held high never restarts
    startEdge = link.job_start_req & ~r.startPrev;

    // Only codes in the mirrored ranges are passed on as alarm equivalents
    alarmEquiv = kernelAlarmValid &
                 (((kernelAlarmCode >= pah_pkg::ALARM_A_LO) &&
                   (kernelAlarmCode <= pah_pkg::ALARM_A_HI)) ||
                  ((kernelAlarmCode >= pah_pkg::ALARM_B_LO) &&
                   (kernelAlarmCode <= pah_pkg::ALARM_B_HI)));
    // Minus zero is still zero speed, so the sign alone does not make it negative
    feedZero = (link.feedrate_value[30:0] == 31'h0);
    feedNeg = link.feedrate_value[pah_pkg::FEED_SIGN_BIT] & ~feedZero;
    // Index positions count from one up to the configured count
    indexBad = (link.target_position == 32'h0) ||
               (link.target_position > indexCount);

    // Start checks, most serious cause first
    if (systemAlarm) begin
      startFault = pah_pkg::FAULT_SYSTEM;
    end else if (alarmEquiv) begin
      startFault = kernelAlarmCode;
    end else if (axisMovingAtHandover) begin
      startFault = pah_pkg::FAULT_MOVING;
    end else if (axisJogOrRef) begin
      startFault = pah_pkg::FAULT_JOG_REF;
    end else if (channelBlocksStart) begin
      startFault = pah_pkg::FAULT_CHANNEL;
    end else if (link.indexing_req && !axisIsIndexing) begin
      startFault = pah_pkg::FAULT_NOT_INDEX;
    end else if (link.indexing_req && indexBad) begin
      startFault = pah_pkg::FAULT_BAD_INDEX;
    end else if (feedNeg) begin
      startFault = pah_pkg::FAULT_NEG_VELO;
    end else if (feedZero) begin
      startFault = pah_pkg::FAULT_ZERO_VELO;
    end else if (!gearStageValid) begin
      startFault = pah_pkg::FAULT_GEAR;
    end else if (link.shortest_path_req && !shortestPathOk) begin
      startFault = pah_pkg::FAULT_SHORT_NO;
    end else if (link.absolute_negative_dir_req && !absNegOk) begin
      startFault = pah_pkg::FAULT_NEG_NO;
    end else if (link.absolute_positive_dir_req && !absPosOk) begin
      startFault = pah_pkg::FAULT_POS_NO;
    end else begin
      startFault = pah_pkg::FAULT_NONE;
    end

    // Faults while traversing; an axial abort ends the move short of target
    if (systemAlarm) begin
      runFault = pah_pkg::FAULT_SYSTEM;
    end else if (alarmEquiv) begin
      runFault = kernelAlarmCode;
    end else if (swLimitPlus) begin
      runFault = pah_pkg::FAULT_SW_PLUS;
    end else if (swLimitMinus) begin
      runFault = pah_pkg::FAULT_SW_MINUS;
    end else if (workLimitPlus) begin
      runFault = pah_pkg::FAULT_WA_PLUS;
    end else if (workLimitMinus) begin
      runFault = pah_pkg::FAULT_WA_MINUS;
    end else if (motionNotReached || axialAbort) begin
      runFault = pah_pkg::FAULT_NOT_REACH;
    end else begin
      runFault = pah_pkg::FAULT_NONE;
    end

    case (r.state)
      pah_pkg::DEV_IDLE: begin
        if (startEdge) begin
          next_r.activeFlag = 1'b1;
          // Mode bits are latched once so the move cannot change mid-job
          if (link.incremental_move_req) begin
            next_r.motionMode = pah_pkg::MOVE_INC;
          end else if (link.shortest_path_req) begin
            next_r.motionMode = pah_pkg::MOVE_SHORT;
          end else if (link.absolute_negative_dir_req) begin
            next_r.motionMode = pah_pkg::MOVE_ABS_NEG;
          end else if (link.absolute_positive_dir_req) begin
            next_r.motionMode = pah_pkg::MOVE_ABS_POS;
          end else begin
            next_r.motionMode = pah_pkg::MOVE_ABS;
          end
          if (link.indexing_req) begin
            next_r.targetUnit = pah_pkg::UNIT_INDEX;
          end else if (axisIsRotary) begin
            next_r.targetUnit = pah_pkg::UNIT_DEG;
          end else if (link.inch_units_req) begin
            next_r.targetUnit = pah_pkg::UNIT_INCH;
          end else begin
            next_r.targetUnit = pah_pkg::UNIT_MM;
          end
          next_r.feedRpm = axisIsRotary | axisIsSpindle;
          next_r.motionTarget = link.target_position;
          next_r.motionFeed = link.feedrate_value;
          if (startFault != pah_pkg::FAULT_NONE) begin
            next_r.refusedFlag = 1'b1;
            next_r.faultCode = startFault;
            next_r.state = pah_pkg::DEV_ACK;
          end else begin
            next_r.motionStart = 1'b1;
            next_r.state = pah_pkg::DEV_RUN;
          end
        end
      end
      pah_pkg::DEV_RUN: begin
        // Start edges and a falling start are both ignored here
        if (runFault != pah_pkg::FAULT_NONE) begin
          next_r.travErrFlag = 1'b1;
          next_r.faultCode = runFault;
          next_r.motionStop = 1'b1;
          next_r.state = pah_pkg::DEV_ACK;
        end else if (motionDone) begin
          next_r.reachedFlag = 1'b1;
          next_r.state = pah_pkg::DEV_ACK;
        end
      end
      pah_pkg::DEV_ACK: begin
        // Acknowledgement stands until the controller lets go of start
        if (!link.job_start_req) begin
          next_r.activeFlag = 1'b0;
          next_r.reachedFlag = 1'b0;
          next_r.refusedFlag = 1'b0;
          next_r.travErrFlag = 1'b0;
          next_r.faultCode = pah_pkg::FAULT_NONE;
          next_r.state = pah_pkg::DEV_IDLE;
        end
      end
      default: begin
        next_r.state = pah_pkg::DEV_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign link.job_active_flag     = r.activeFlag;
  assign link.target_reached_flag = r.reachedFlag;
  assign link.start_refused_flag  = r.refusedFlag;
  assign link.traverse_error_flag = r.travErrFlag;
  assign link.fault_code_byte     = r.faultCode;
  assign motionStart              = r.motionStart;
  assign motionStop               = r.motionStop;
  assign motionMode               = r.motionMode;
  assign targetUnit               = r.targetUnit;
  assign feedRpm                  = r.feedRpm;
  assign motionTarget             = r.motionTarget;
  assign motionFeed               = r.motionFeed;

endmodule

//--- pah_link_if.sv
// Link between the controller end and the axis end of the positioning handshake.
// Assumes both ends are clocked by the same core_clk.
`timescale 1ns/1ns
interface pah_link_if;
  logic        job_start_req;
  logic        incremental_move_req;
  logic        shortest_path_req;
  logic        inch_units_req;
  logic        absolute_negative_dir_req;
  logic        absolute_positive_dir_req;
  logic        indexing_req;
  logic [31:0] target_position;
  logic [31:0] feedrate_value;
  logic        start_refused_flag;
  logic        traverse_error_flag;
  logic        target_reached_flag;
  logic        job_active_flag;
  logic [7:0]  fault_code_byte;

  modport device (
    input  job_start_req, incremental_move_req, shortest_path_req, inch_units_req,
    input  absolute_negative_dir_req, absolute_positive_dir_req, indexing_req,
    input  target_position, feedrate_value,
    output start_refused_flag, traverse_error_flag, target_reached_flag,
    output job_active_flag, fault_code_byte
  );

  modport plc (
    output job_start_req, incremental_move_req, shortest_path_req, inch_units_req,
    output absolute_negative_dir_req, absolute_positive_dir_req, indexing_req,
    output target_position, feedrate_value,
    input  start_refused_flag, traverse_error_flag, target_reached_flag,
    input  job_active_flag, fault_code_byte
  );
endinterface

//--- pah_link_sva.sv
// Checker for the link between the controller end and the axis end.
// Assumes it sits beside the link interface, on core_clk with synchronous rst.
`timescale 1ns/1ns
module pah_link_sva (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // Link signals
  input wire logic       job_start_req,
  input wire logic       start_refused_flag,
  input wire logic       traverse_error_flag,
  input wire logic       target_reached_flag,
  input wire logic       job_active_flag,
  input wire logic [7:0] fault_code_byte
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire err = start_refused_flag | traverse_error_flag;
  wire ack = err | target_reached_flag;
  property p_begin; $rose(job_start_req) && !job_active_flag |=> job_active_flag; endproperty
  property p_edge; $rose(job_active_flag) |-> $past(job_start_req) && !$past(job_start_req, 2);
  endproperty
  property p_pos; target_reached_flag |-> job_active_flag && !err && fault_code_byte == 8'h00;
  endproperty
  property p_neg;
    err |-> job_active_flag && fault_code_byte != 8'h00 && !(start_refused_flag && traverse_error_flag);
  endproperty
  property p_nocode; !err |-> fault_code_byte == 8'h00; endproperty
  property p_stand;
    ack && job_start_req |=> job_active_flag && $stable({err, target_reached_flag, fault_code_byte});
  endproperty
  property p_release; ack && !job_start_req |=> !job_active_flag && !ack; endproperty
  property p_hold; job_start_req && !ack |=> job_start_req; endproperty
  // Reset itself is the cause here, so it cannot also disable the check
  property p_reset;
    @(posedge core_clk) disable iff (1'b0) rst |=> !job_active_flag && !ack && fault_code_byte == 8'h00;
  endproperty
  a_begin: assert property (p_begin) else $error("no active after start edge");
  a_edge: assert property (p_edge) else $error("active without start edge");
  a_pos: assert property (p_pos) else $error("bad positive acknowledge");
  a_neg: assert property (p_neg) else $error("bad negative acknowledge");
  a_nocode: assert property (p_nocode) else $error("code without error flag");
  a_stand: assert property (p_stand) else $error("feedback moved while start high");
  a_release: assert property (p_release) else $error("flags not cleared");
  a_hold: assert property (p_hold) else $error("start dropped early");
  a_reset: assert property (p_reset) else $error("feedback not cleared by reset");
  c_reached: cover property ($rose(target_reached_flag));
  c_refused: cover property ($rose(start_refused_flag));
  c_traverse: cover property ($rose(traverse_error_flag));
endmodule

//--- pah_pkg.sv
// Shared constants and types for the controller-to-axis positioning handshake.
// Assumes both ends run on one clock, core_clk, with a synchronous reset.
package pah_pkg;

  // Handshake state of the axis end
  typedef enum logic [1:0] {
    DEV_IDLE = 2'b00,
    DEV_RUN  = 2'b01,
    DEV_ACK  = 2'b10
  } pah_dev_state_t;

  // Handshake state of the controller end
  typedef enum logic [1:0] {
    HOST_IDLE = 2'b00,
    HOST_REQ  = 2'b01,
    HOST_REL  = 2'b10
  } pah_host_state_t;

  // Move type handed to the motion core
  typedef enum logic [2:0] {
    MOVE_ABS     = 3'b000,
    MOVE_INC     = 3'b001,
    MOVE_SHORT   = 3'b010,
    MOVE_ABS_NEG = 3'b011,
    MOVE_ABS_POS = 3'b100
  } pah_move_t;

  // Unit in which the target field is read
  typedef enum logic [1:0] {
    UNIT_DEG   = 2'b00,
    UNIT_MM    = 2'b01,
    UNIT_INCH  = 2'b10,
    UNIT_INDEX = 2'b11
  } pah_unit_t;

  // Fault codes
  localparam logic [7:0] FAULT_NONE      = 8'h00;
  localparam logic [7:0] FAULT_MOVING    = 8'h1e;
  localparam logic [7:0] FAULT_JOG_REF   = 8'h32;
  localparam logic [7:0] FAULT_CHANNEL   = 8'h3c;
  localparam logic [7:0] FAULT_NEG_VELO  = 8'h6e;
  localparam logic [7:0] FAULT_ZERO_VELO = 8'h6f;
  localparam logic [7:0] FAULT_GEAR      = 8'h70;
  localparam logic [7:0] FAULT_NOT_REACH = 8'h73;
  localparam logic [7:0] FAULT_NOT_INDEX = 8'h78;
  localparam logic [7:0] FAULT_BAD_INDEX = 8'h79;
  localparam logic [7:0] FAULT_SHORT_NO  = 8'h7d;
  localparam logic [7:0] FAULT_NEG_NO    = 8'h7e;
  localparam logic [7:0] FAULT_POS_NO    = 8'h7f;
  localparam logic [7:0] FAULT_SW_PLUS   = 8'h82;
  localparam logic [7:0] FAULT_SW_MINUS  = 8'h83;
  localparam logic [7:0] FAULT_WA_PLUS   = 8'h84;
  localparam logic [7:0] FAULT_WA_MINUS  = 8'h85;
  localparam logic [7:0] FAULT_SYSTEM    = 8'hc8;
  // Ranges of codes that mirror kernel alarms
  localparam logic [7:0] ALARM_A_LO      = 8'h64;
  localparam logic [7:0] ALARM_A_HI      = 8'h6d;
  localparam logic [7:0] ALARM_B_LO      = 8'h87;
  localparam logic [7:0] ALARM_B_HI      = 8'h88;

  // Sign bit of a real-valued word
  localparam int FEED_SIGN_BIT = 31;

  // Controller register byte offsets
  localparam logic [3:0] REG_CMD    = 4'h0;
  localparam logic [3:0] REG_TARGET = 4'h4;
  localparam logic [3:0] REG_FEED   = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;

  // Command register fields
  localparam int CMD_INC_BIT   = 0;
  localparam int CMD_SHORT_BIT = 1;
  localparam int CMD_INCH_BIT  = 2;
  localparam int CMD_NEG_BIT   = 3;
  localparam int CMD_POS_BIT   = 4;
  localparam int CMD_INDEX_BIT = 5;
  localparam int CMD_GO_BIT    = 8;
  localparam int CMD_MODE_W    = 6;

  // Status register fields
  localparam int ST_REFUSED_BIT = 0;
  localparam int ST_TRAV_BIT    = 1;
  localparam int ST_REACHED_BIT = 6;
  localparam int ST_ACTIVE_BIT  = 7;
  localparam int ST_BUSY_BIT    = 8;
  localparam int ST_CODE_LSB    = 16;

endpackage

//--- pah_plc_ctrl.sv
// Controller end of the positioning handshake with an Avalon-MM slave for software.
// Assumes the axis end runs on core_clk; the bus master holds each request until
// it sees waitrequest low.
`timescale 1ns/1ns
module pah_plc_ctrl (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [3:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWriteData,
  output logic [31:0]      avsReadData,
  output logic             avsWaitRequest,
  // Axis link
  pah_link_if.plc          link
);

  typedef struct packed {
    pah_pkg::pah_host_state_t       state;
    logic                           served;
    logic                           waitReq;
    logic [31:0]                    readData;
    logic [pah_pkg::CMD_MODE_W-1:0] modeBits;
    logic [31:0]                    target;
    logic [31:0]                    feed;
    logic                           startReq;
    logic                           lastReached;
    logic                           lastRefused;
    logic                           lastTrav;
    logic [7:0]                     lastCode;
  } pah_host_regs_t;

  pah_host_regs_t r;
  pah_host_regs_t next_r;

  logic        busReq;
  logic        accept;
  logic        ackSeen;
  logic [31:0] statusWord;

  always_comb begin
    next_r = r;
    busReq = avsRead | avsWrite;
    // One wait cycle, then the answer; the write lands on the answering edge
    next_r.served = busReq & ~r.served;
    next_r.waitReq = ~next_r.served;
    accept = r.served & avsWrite;

    statusWord = 32'h0;
    statusWord[pah_pkg::ST_REFUSED_BIT] = r.lastRefused;
    statusWord[pah_pkg::ST_TRAV_BIT] = r.lastTrav;
    statusWord[pah_pkg::ST_REACHED_BIT] = r.lastReached;
    statusWord[pah_pkg::ST_ACTIVE_BIT] = link.job_active_flag;
    statusWord[pah_pkg::ST_BUSY_BIT] = (r.state != pah_pkg::HOST_IDLE);
    statusWord[pah_pkg::ST_CODE_LSB +: 8] = r.lastCode;

    if (busReq && !r.served && avsRead) begin
      case (avsAddress)
        pah_pkg::REG_CMD:    next_r.readData = {26'h0, r.modeBits};
        pah_pkg::REG_TARGET: next_r.readData = r.target;
        pah_pkg::REG_FEED:   next_r.readData = r.feed;
        pah_pkg::REG_STATUS: next_r.readData = statusWord;
        default:             next_r.readData = 32'h0;
      endcase
    end

    // Acknowledgement counts only while the axis shows itself active
    ackSeen = link.job_active_flag &
              (link.target_reached_flag | link.start_refused_flag |
               link.traverse_error_flag);

    case (r.state)
      pah_pkg::HOST_IDLE: begin
        // Job fields change only between jobs, so they stay steady while start is high
        if (accept && avsAddress == pah_pkg::REG_TARGET) begin
          next_r.target = avsWriteData;
        end
        if (accept && avsAddress == pah_pkg::REG_FEED) begin
          next_r.feed = avsWriteData;
        end
        if (accept && avsAddress == pah_pkg::REG_CMD) begin
          next_r.modeBits = avsWriteData[pah_pkg::CMD_MODE_W-1:0];
          if (avsWriteData[pah_pkg::CMD_GO_BIT]) begin
            // Start has been low since the last job, so this is a fresh edge
            next_r.startReq = 1'b1;
            next_r.state = pah_pkg::HOST_REQ;
          end
        end
      end
      pah_pkg::HOST_REQ: begin
        if (ackSeen) begin
          next_r.lastReached = link.target_reached_flag;
          next_r.lastRefused = link.start_refused_flag;
          next_r.lastTrav = link.traverse_error_flag;
          next_r.lastCode = link.fault_code_byte;
          next_r.startReq = 1'b0;
          next_r.state = pah_pkg::HOST_REL;
        end
      end
      pah_pkg::HOST_REL: begin
        if (!link.job_active_flag) begin
          next_r.state = pah_pkg::HOST_IDLE;
        end
      end
      default: begin
        next_r.state = pah_pkg::HOST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      r <= '0;
      r.waitReq <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign avsReadData                    = r.readData;
  assign avsWaitRequest                 = r.waitReq;
  assign link.job_start_req             = r.startReq;
  assign link.incremental_move_req      = r.modeBits[pah_pkg::CMD_INC_BIT];
  assign link.shortest_path_req         = r.modeBits[pah_pkg::CMD_SHORT_BIT];
  assign link.inch_units_req            = r.modeBits[pah_pkg::CMD_INCH_BIT];
  assign link.absolute_negative_dir_req = r.modeBits[pah_pkg::CMD_NEG_BIT];
  assign link.absolute_positive_dir_req = r.modeBits[pah_pkg::CMD_POS_BIT];
  assign link.indexing_req              = r.modeBits[pah_pkg::CMD_INDEX_BIT];
  assign link.target_position           = r.target;
  assign link.feedrate_value            = r.feed;

endmodule

//--- plc_axis_positioning_handshake_tb_top.sv
// Testbench joining controller end and axis end, driven over the Avalon-MM port.
// Assumes core_clk at 50 MHz and motion-core inputs given as static levels per job.
`timescale 1ns/1ns
module plc_axis_positioning_handshake_tb_top;
  localparam logic [31:0] ONE = 32'h3f800000;
  logic               core_clk = 1'b0;
  logic               rst = 1'b1;
  logic [3:0]         avsAddress = 4'h0;
  logic               avsRead = 1'b0;
  logic               avsWrite = 1'b0;
  logic [31:0]        avsWriteData = 32'h0;
  logic [31:0]        avsReadData;
  logic               avsWaitRequest;
  logic [15:0]        cnd = 16'h0;
  logic [31:0]        rd;
  logic [5:0]         md [5] = '{6'h00, 6'h01, 6'h02, 6'h08, 6'h10};
  int                 fails = 0;
  int                 cmpCount = 0;
  int                 cyc = 0;
  pah_pkg::pah_move_t motionMode;
  pah_pkg::pah_unit_t targetUnit;
  logic               feedRpm;
  logic [31:0]        motionTarget;
  always #10 core_clk = ~core_clk;
  pah_link_if link ();
  pah_plc_ctrl pah_plc_ctrl_inst (.core_clk(core_clk), .rst(rst), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .link(link));
  // Each cnd bit forces one axis condition; cnd[15] turns the plus limits into
  // minus ones, cuts indexCount from 4 to 1 and marks a spindle when the axis is not an indexing axis
  pah_axis_device pah_axis_device_inst (.core_clk(core_clk), .rst(rst), .link(link),
    .axisIsRotary(cnd[13]), .axisIsSpindle(cnd[15] & ~cnd[14]), .axisIsIndexing(cnd[14]),
    .indexCount(cnd[15] ? 32'h1 : 32'h4), .axisMovingAtHandover(cnd[0]), .axisJogOrRef(cnd[1]),
    .channelBlocksStart(cnd[2]), .gearStageValid(!cnd[3]), .shortestPathOk(!cnd[4]),
    .absNegOk(!cnd[5]), .absPosOk(!cnd[6]), .systemAlarm(cnd[7]), .kernelAlarmValid(cnd[8]),
    .kernelAlarmCode(8'h69), .swLimitPlus(cnd[9] & ~cnd[15]), .swLimitMinus(cnd[9] & cnd[15]),
    .workLimitPlus(cnd[10] & ~cnd[15]), .workLimitMinus(cnd[10] & cnd[15]),
    .motionDone(~|cnd[12:9]), .motionNotReached(cnd[11]),
    .axialAbort(cnd[12]), .motionStart(), .motionStop(), .motionMode(motionMode),
    .targetUnit(targetUnit), .feedRpm(feedRpm), .motionTarget(motionTarget), .motionFeed());
  pah_link_sva pah_link_sva_inst (.core_clk(core_clk), .rst(rst),
    .job_start_req(link.job_start_req), .start_refused_flag(link.start_refused_flag),
    .traverse_error_flag(link.traverse_error_flag), .target_reached_flag(link.target_reached_flag),
    .job_active_flag(link.job_active_flag), .fault_code_byte(link.fault_code_byte));
  task complete_run;
    $display("Compared %0d, mismatches %0d", cmpCount, fails);
    if (fails == 0 && cmpCount > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] e);
    cmpCount++;
    if (g !== e) begin
      fails++;
      $display("BAD at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avsAddress <= a;
    avsWrite <= w;
    avsRead <= !w;
    avsWriteData <= d;
    @(posedge core_clk);
    while (avsWaitRequest !== 1'b0) @(posedge core_clk);
    rd = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge core_clk);
  endtask
  // One whole job: set up, go, poll until idle, then compare the kept result
  task j(input logic [5:0] c, input logic [31:0] fd, input logic [15:0] k, input logic [7:0] code,
      input logic [2:0] f);
    cnd <= k;
    bus(1'b1, 4'h4, 32'h2);
    bus(1'b1, 4'h8, fd);
    bus(1'b1, 4'h0, {23'h0, 1'b1, 2'h0, c});
    repeat (30) begin
      bus(1'b0, 4'hc, 32'h0);
      if (rd[8] === 1'b0) break;
    end
    cmp(rd & 32'h00ff01c3, {8'h00, code, 9'h0, f[2], 4'h0, f[1:0]});
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      complete_run;
    end
  end
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    cmp({link.job_active_flag, link.target_reached_flag, link.fault_code_byte}, 32'h0);
    bus(1'b0, 4'hc, 32'h0);
    cmp(rd, 32'h0);
    bus(1'b0, 4'h2, 32'h0);
    cmp(rd, 32'h0);
    for (int i = 0; i < 5; i++) begin
      j(md[i], ONE, 16'h0, 8'h00, 3'b100);
      cmp(motionMode, i);
    end
    cmp(feedRpm, 32'h0);
    cmp(targetUnit, 32'h1);
    j(6'h04, ONE, 16'h0000, 8'h00, 3'b100);
    cmp(targetUnit, 32'h2);
    j(6'h04, ONE, 16'h2000, 8'h00, 3'b100);
    cmp(targetUnit, 32'h0);
    cmp(feedRpm, 32'h1);
    j(6'h20, ONE, 16'h4000, 8'h00, 3'b100);
    cmp(targetUnit, 32'h3);
    cmp(motionTarget, 32'h2);
    j(6'h00, ONE, 16'h0001, 8'h1e, 3'b001);
    j(6'h00, ONE, 16'h0002, 8'h32, 3'b001);
    j(6'h00, ONE, 16'h0004, 8'h3c, 3'b001);
    j(6'h00, 32'hbf800000, 16'h0, 8'h6e, 3'b001);
    j(6'h00, 32'h00000000, 16'h0, 8'h6f, 3'b001);
    j(6'h00, 32'h80000000, 16'h0, 8'h6f, 3'b001);
    j(6'h00, ONE, 16'h0008, 8'h70, 3'b001);
    j(6'h20, ONE, 16'h0000, 8'h78, 3'b001);
    j(6'h20, ONE, 16'hc000, 8'h79, 3'b001);
    j(6'h02, ONE, 16'h0010, 8'h7d, 3'b001);
    j(6'h08, ONE, 16'h0020, 8'h7e, 3'b001);
    j(6'h10, ONE, 16'h0040, 8'h7f, 3'b001);
    j(6'h00, ONE, 16'h0100, 8'h69, 3'b001);
    j(6'h00, ONE, 16'h0080, 8'hc8, 3'b001);
    j(6'h00, ONE, 16'h0200, 8'h82, 3'b010);
    j(6'h00, ONE, 16'h0400, 8'h84, 3'b010);
    j(6'h00, ONE, 16'h0800, 8'h73, 3'b010);
    j(6'h00, ONE, 16'h1000, 8'h73, 3'b010);
    j(6'h00, ONE, 16'h0000, 8'h00, 3'b100);
    j(6'h00, ONE, 16'h8000, 8'h00, 3'b100);
    cmp(feedRpm, 32'h1);
    j(6'h00, ONE, 16'h8200, 8'h83, 3'b010);
    j(6'h00, ONE, 16'h8400, 8'h85, 3'b010);
    complete_run;
  end
endmodule
